//--- src/acc_clk_div.sv
/*
 * Enable-pulse divider: pulses once every (divisor + 1) input enables.
 * Assumes inEn is a one-cycle pulse on core_clk.
 */
`timescale 1ns/10ps
module acc_clk_div #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic [W-1:0] divisor,
    input wire logic inEn,
    // Output
    output logic outEn
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic outEn_next;
    wire logic atTerm = (count_reg >= divisor);

    // Period is divisor + 1 input pulses
    assign count_next = (!run) ? '0 : (inEn ? (atTerm ? '0 : count_reg + 1'b1) : count_reg);
    assign outEn_next = run && inEn && atTerm;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
            outEn <= 1'b0;
        end else begin
            count_reg <= count_next;
            outEn <= outEn_next;
        end
    end
endmodule : acc_clk_div

//--- src/acc_core_clock_config.sv
/*
 * Converter clock and core-enable configuration register with clock enables.
 * Assumes source enables arrive as pulses on core_clk; a plain strobe bus.
 */
// Functional notes
// - Source select 11 picks PLL, 10 picks RC, others system-derived
// - Six-bit divider makes one common core source clock for all cores
// - Common period equals field value plus one source periods
// - Each core divides the common clock by its own divider
// - Bit 7 enables the shared core
// - Bits 3 to 0 enable dedicated cores 3 to 0
`timescale 1ns/10ps
module acc_core_clock_config #(
    parameter int NCORE = acc_pkg::NUM_DED_CORES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Source clock enables
    input wire logic sysClkEn,
    input wire logic sysClkX2En,
    input wire logic fastRcOscEn,
    input wire logic auxPllOutEn,
    // Core clocks and enables
    output logic commonCoreSrcEn,
    output logic sharedCoreClkEn,
    output logic [NCORE-1:0] dedCoreClkEn,
    output logic sharedCoreEnable,
    output logic [NCORE-1:0] dedCoreEnable
);
    // ******************************************************************
    // Registers
    // ******************************************************************
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic [6:0] shrDiv_reg;
    logic [6:0] shrDiv_next;
    logic [6:0] coreDiv_reg [NCORE];
    logic [6:0] coreDiv_next [NCORE];
    logic moduleSrcEn;
    logic [NCORE-1:0] dedClkRaw;
    logic shrClkRaw;

    wire logic cfgHit = (regAddr == acc_pkg::ADDR_CLK_CORE_EN);
    wire logic shrHit = (regAddr == acc_pkg::ADDR_SHARED_DIV);
    // Masked write keeps reserved bits at zero
    assign cfg_next = (regWr && cfgHit) ? (regWrData & acc_pkg::CFG_WRITE_MASK) : cfg_reg;
    assign shrDiv_next = (regWr && shrHit) ? regWrData[6:0] : shrDiv_reg;

    wire logic [1:0] srcSel = cfg_reg[acc_pkg::SRC_SEL_MSB:acc_pkg::SRC_SEL_LSB];
    wire logic [5:0] comDiv = cfg_reg[acc_pkg::COM_DIV_MSB:acc_pkg::COM_DIV_LSB];
    assign sharedCoreEnable = cfg_reg[acc_pkg::SHR_EN_BIT];
    assign dedCoreEnable = cfg_reg[acc_pkg::DED_EN_MSB:acc_pkg::DED_EN_LSB];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= acc_pkg::CFG_RESET;
            shrDiv_reg <= acc_pkg::CORE_DIV_RESET;
        end else begin
            cfg_reg <= cfg_next;
            shrDiv_reg <= shrDiv_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCORE; g++) begin : gCoreDiv
            localparam logic [3:0] A = 4'(acc_pkg::ADDR_CORE_DIV0 + g);
            assign coreDiv_next[g] = (regWr && regAddr == A) ? regWrData[6:0] : coreDiv_reg[g];
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    coreDiv_reg[g] <= acc_pkg::CORE_DIV_RESET;
                end else begin
                    coreDiv_reg[g] <= coreDiv_next[g];
                end
            end
            // Per-core divider, runs only while the core is enabled
            acc_clk_div #(.W(acc_pkg::CORE_DIV_W)) uDedDiv (
                .core_clk(core_clk),
                .resetn(resetn),
                .run(dedCoreEnable[g]),
                .divisor(coreDiv_reg[g]),
                .inEn(commonCoreSrcEn),
                .outEn(dedClkRaw[g])
            );
        end
    endgenerate
    assign dedCoreClkEn = dedClkRaw;

    // ******************************************************************
    // Readback
    // ******************************************************************
    logic [15:0] rdMux;
    logic [15:0] statusWord;
    assign statusWord = {12'h000, sharedCoreEnable, 1'b0, srcSel};
    always_comb begin
        rdMux = 16'h0000;
        if (cfgHit) begin
            rdMux = cfg_reg;
        end else if (regAddr == acc_pkg::ADDR_CLK_STATUS) begin
            rdMux = statusWord;
        end else if (shrHit) begin
            rdMux = {9'h000, shrDiv_reg};
        end
        for (int i = 0; i < NCORE; i++) begin
            if (regAddr == 4'(acc_pkg::ADDR_CORE_DIV0 + i)) begin
                rdMux = {9'h000, coreDiv_reg[i]};
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            regRdData <= rdMux;
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // ******************************************************************
    // Clock tree
    // ******************************************************************
    acc_src_mux uSrcMux (
        .core_clk(core_clk),
        .resetn(resetn),
        .sel(srcSel),
        .srcEn({auxPllOutEn, fastRcOscEn, sysClkX2En, sysClkEn}),
        .moduleSrcEn(moduleSrcEn)
    );

    acc_clk_div #(.W(acc_pkg::COM_DIV_W)) uComDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(1'b1),
        .divisor(comDiv),
        .inEn(moduleSrcEn),
        .outEn(commonCoreSrcEn)
    );

    acc_clk_div #(.W(acc_pkg::CORE_DIV_W)) uShrDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(sharedCoreEnable),
        .divisor(shrDiv_reg),
        .inEn(commonCoreSrcEn),
        .outEn(shrClkRaw)
    );
    assign sharedCoreClkEn = shrClkRaw;

    // ******************************************************************
    // Checks
    // ******************************************************************
    property p_reserved_zero;
        @(posedge core_clk) disable iff (!resetn) cfg_reg[6:4] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_write_lands;
        @(posedge core_clk) disable iff (!resetn)
            (regWr && cfgHit) |=> (cfg_reg == ($past(regWrData) & acc_pkg::CFG_WRITE_MASK));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("config write lost");

    property p_shared_en;
        @(posedge core_clk) disable iff (!resetn)
            (regWr && cfgHit) |=> sharedCoreEnable == $past(regWrData[7]);
    endproperty
    a_shared_en: assert property (p_shared_en) else $error("shared enable wrong");

    property p_ded_en;
        @(posedge core_clk) disable iff (!resetn)
            (regWr && cfgHit) |=> dedCoreEnable == $past(regWrData[3:0]);
    endproperty
    a_ded_en: assert property (p_ded_en) else $error("core enable wrong");

    property p_src_pll;
        @(posedge core_clk) disable iff (!resetn)
            (srcSel == acc_pkg::SRC_AUXILIARY_PLL_OUTPUT && auxPllOutEn) |=> moduleSrcEn;
    endproperty
    a_src_pll: assert property (p_src_pll) else $error("pll not selected");

    property p_src_frc;
        @(posedge core_clk) disable iff (!resetn)
            (srcSel == acc_pkg::SRC_FRC && !fastRcOscEn) |=> !moduleSrcEn;
    endproperty
    a_src_frc: assert property (p_src_frc) else $error("rc select leaks");

    property p_div_one;
        @(posedge core_clk) disable iff (!resetn)
            (comDiv == 6'h00 && moduleSrcEn && $stable(comDiv)) |=> commonCoreSrcEn;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one failed");

    property p_ded_off;
        @(posedge core_clk) disable iff (!resetn)
            !dedCoreEnable[0] |=> !dedCoreClkEn[0];
    endproperty
    a_ded_off: assert property (p_ded_off) else $error("disabled core clocked");

    property p_shr_off;
        @(posedge core_clk) disable iff (!resetn)
            !sharedCoreEnable |=> !sharedCoreClkEn;
    endproperty
    a_shr_off: assert property (p_shr_off) else $error("shared core clocked");

    property p_rd_zero;
        @(posedge core_clk) disable iff (!resetn) !regRd |=> regRdData == 16'h0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not idle");

    // ******************************************************************
    // Source selection and divider chain checks
    // ******************************************************************
    // Every code must pass its own enable through the one-cycle mux stage
    property p_src_sys_a;
        @(posedge core_clk) disable iff (!resetn)
            (srcSel == acc_pkg::SRC_SYS_A && sysClkEn) |=> moduleSrcEn;
    endproperty
    a_src_sys_a: assert property (p_src_sys_a) else $error("system source lost");

    property p_src_sys_b;
        @(posedge core_clk) disable iff (!resetn)
            (srcSel == acc_pkg::SRC_SYS_B && sysClkX2En) |=> moduleSrcEn;
    endproperty
    a_src_sys_b: assert property (p_src_sys_b) else $error("doubled source lost");

    property p_src_frc_on;
        @(posedge core_clk) disable iff (!resetn)
            (srcSel == acc_pkg::SRC_FRC && fastRcOscEn) |=> moduleSrcEn;
    endproperty
    a_src_frc_on: assert property (p_src_frc_on) else $error("rc source lost");

    property p_src_pll_off;
        @(posedge core_clk) disable iff (!resetn)
            (srcSel == acc_pkg::SRC_AUXILIARY_PLL_OUTPUT && !auxPllOutEn) |=> !moduleSrcEn;
    endproperty
    a_src_pll_off: assert property (p_src_pll_off) else $error("pll select leaks");

    // No stage may pulse without a pulse one stage up
    property p_common_gated;
        @(posedge core_clk) disable iff (!resetn)
            !moduleSrcEn |=> !commonCoreSrcEn;
    endproperty
    a_common_gated: assert property (p_common_gated) else $error("common without source");

    property p_shr_gated;
        @(posedge core_clk) disable iff (!resetn)
            !commonCoreSrcEn |=> !sharedCoreClkEn;
    endproperty
    a_shr_gated: assert property (p_shr_gated) else $error("shared without common");

    property p_ded_gated;
        @(posedge core_clk) disable iff (!resetn)
            !commonCoreSrcEn |=> (dedCoreClkEn == '0);
    endproperty
    a_ded_gated: assert property (p_ded_gated) else $error("core clock without common");

    property p_ded_div_one;
        @(posedge core_clk) disable iff (!resetn)
            (dedCoreEnable[0] && coreDiv_reg[0] == '0 && commonCoreSrcEn) |=> dedCoreClkEn[0];
    endproperty
    a_ded_div_one: assert property (p_ded_div_one) else $error("core divide by one failed");

    property p_ded_all_off;
        @(posedge core_clk) disable iff (!resetn)
            (dedCoreClkEn & ~$past(dedCoreEnable)) == '0;
    endproperty
    a_ded_all_off: assert property (p_ded_all_off) else $error("disabled core pulsed");

    // ******************************************************************
    // Register checks
    // ******************************************************************
    property p_rd_reserved;
        @(posedge core_clk) disable iff (!resetn)
            (regRd && cfgHit) |=> (regRdData[6:4] == 3'h0);
    endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits read back");

    property p_rd_status;
        @(posedge core_clk) disable iff (!resetn)
            (regRd && regAddr == acc_pkg::ADDR_CLK_STATUS) |=>
                (regRdData == {12'h000, $past(sharedCoreEnable), 1'b0, $past(srcSel)});
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status readback wrong");

    property p_other_write;
        @(posedge core_clk) disable iff (!resetn)
            (regWr && !cfgHit) |=> $stable(cfg_reg);
    endproperty
    a_other_write: assert property (p_other_write) else $error("stray write hit config");

    property p_shr_div_write;
        @(posedge core_clk) disable iff (!resetn)
            (regWr && shrHit) |=> (shrDiv_reg == $past(regWrData[6:0]));
    endproperty
    a_shr_div_write: assert property (p_shr_div_write) else $error("shared divider lost");

    c_common: cover property (@(posedge core_clk) commonCoreSrcEn);
    c_shared: cover property (@(posedge core_clk) sharedCoreClkEn);
    c_ded: cover property (@(posedge core_clk) dedCoreClkEn[3]);
    c_pll: cover property (@(posedge core_clk) srcSel == acc_pkg::SRC_AUXILIARY_PLL_OUTPUT && moduleSrcEn);
    c_frc: cover property (@(posedge core_clk) srcSel == acc_pkg::SRC_FRC && moduleSrcEn);
endmodule : acc_core_clock_config

//--- src/acc_pkg.sv
/*
 * Constants for the converter clock and core-enable configuration block.
 * Assumes a 16-bit register reached over a plain strobe port.
 */
package acc_pkg;
    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam logic [3:0] ADDR_CLK_CORE_EN = 4'h0;
    localparam logic [3:0] ADDR_CLK_STATUS = 4'h1;
    localparam logic [3:0] ADDR_SHARED_DIV = 4'h2;
    localparam logic [3:0] ADDR_CORE_DIV0 = 4'h3;
    localparam int NUM_DED_CORES = 4;
    localparam int DATA_W = 16;
    localparam int CORE_DIV_W = 7;
    // ******************************************************************
    // Field layout
    // ******************************************************************
    localparam int SRC_SEL_MSB = 15;
    localparam int SRC_SEL_LSB = 14;
    localparam int COM_DIV_MSB = 13;
    localparam int COM_DIV_LSB = 8;
    localparam int COM_DIV_W = 6;
    localparam int SHR_EN_BIT = 7;
    localparam int DED_EN_MSB = 3;
    localparam int DED_EN_LSB = 0;
    localparam logic [15:0] CFG_WRITE_MASK = 16'hFF8F;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [6:0] CORE_DIV_RESET = 7'h00;
    // ******************************************************************
    // Source selection codes
    // ******************************************************************
    typedef enum logic [1:0] {
        SRC_SYS_A = 2'h0,
        SRC_SYS_B = 2'h1,
        SRC_FRC = 2'h2,
        SRC_AUXILIARY_PLL_OUTPUT = 2'h3
    } acc_src_t;
endpackage : acc_pkg

//--- src/acc_src_mux.sv
/*
 * Selects the module source clock enable from four candidate enables.
 * Assumes all candidate enables are one-cycle pulses on core_clk.
 */
`timescale 1ns/10ps
module acc_src_mux (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Select and candidates
    input wire logic [1:0] sel,
    input wire logic [3:0] srcEn,
    // Output
    output logic moduleSrcEn
);
    wire logic picked = srcEn[sel];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            moduleSrcEn <= 1'b0;
        end else begin
            moduleSrcEn <= picked;
        end
    end
endmodule : acc_src_mux

//--- tb/tb_top.sv
/*
 * Self-checking bench for the converter clock and core-enable block.
 * Assumes the design files are compiled first; drives every port itself.
 */
`timescale 1ns/10ps
module tb_top;
    // ******************************************************************
    // Signals
    // ******************************************************************
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData;
    logic [3:0] srcEn = 4'h0;
    logic commonCoreSrcEn;
    logic sharedCoreClkEn;
    logic [3:0] dedCoreClkEn;
    logic sharedCoreEnable;
    logic [3:0] dedCoreEnable;
    wire logic [5:0] probe = {dedCoreClkEn, sharedCoreClkEn, commonCoreSrcEn};
    int fails = 0;
    int n_compared = 0;

    always #5 core_clk = ~core_clk;

    acc_core_clock_config #(.NCORE(4)) u_dut (
        .core_clk(core_clk), .resetn(resetn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData),
        .sysClkEn(srcEn[0]), .sysClkX2En(srcEn[1]),
        .fastRcOscEn(srcEn[2]), .auxPllOutEn(srcEn[3]),
        .commonCoreSrcEn(commonCoreSrcEn), .sharedCoreClkEn(sharedCoreClkEn),
        .dedCoreClkEn(dedCoreClkEn), .sharedCoreEnable(sharedCoreEnable),
        .dedCoreEnable(dedCoreEnable)
    );

    // ******************************************************************
    // Shared tasks
    // ******************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    // Gap in cycles between two pulses of one probe bit, bounded
    task automatic period(input int idx, output int per);
        int n;
        per = 0;
        for (n = 0; n < 300 && probe[idx] !== 1'b1; n++) @(posedge core_clk) #1;
        do begin
            @(posedge core_clk);
            #1 per++;
        end while (probe[idx] !== 1'b1 && per < 300);
    endtask : period

    // ******************************************************************
    // Scenarios
    // ******************************************************************
    task automatic t_reset_and_fields();
        logic [15:0] d;
        rd(acc_pkg::ADDR_CLK_CORE_EN, d);
        check(d, 16'h0000, "reset value");
        check({11'h000, sharedCoreEnable, dedCoreEnable}, 16'h0000, "reset enables");
        wr(acc_pkg::ADDR_CLK_CORE_EN, 16'hFFFF);
        rd(acc_pkg::ADDR_CLK_CORE_EN, d);
        check(d, 16'hFF8F, "unused bits");
        check({11'h000, sharedCoreEnable, dedCoreEnable}, 16'h001F, "all enables");
        for (int k = 0; k < 4; k++) begin
            wr(acc_pkg::ADDR_CLK_CORE_EN, 16'h0001 << k);
            #1 check({11'h000, sharedCoreEnable, dedCoreEnable}, 16'h0001 << k, "core bit");
        end
        wr(acc_pkg::ADDR_CLK_CORE_EN, 16'hC080);
        rd(acc_pkg::ADDR_CLK_STATUS, d);
        check(d, 16'h000B, "status");
        check({11'h000, sharedCoreEnable, dedCoreEnable}, 16'h0010, "shared only");
        rd(4'hF, d);
        check(d, 16'h0000, "unmapped read");
    endtask : t_reset_and_fields

    task automatic t_source_select();
        int n;
        int p;
        for (int c = 0; c < 4; c++) begin
            wr(acc_pkg::ADDR_CLK_CORE_EN, {c[1:0], 14'h0000});
            srcEn <= 4'h0;
            repeat (4) @(posedge core_clk);
            srcEn <= ~(4'h1 << c);
            repeat (3) @(posedge core_clk);
            n = 0;
            repeat (12) begin
                @(posedge core_clk);
                #1 if (commonCoreSrcEn !== 1'b0) n++;
            end
            check(n[15:0], 16'h0000, "unselected source");
            @(posedge core_clk);
            srcEn <= 4'h1 << c;
            period(0, p);
            check(p[15:0], 16'h0001, "selected source");
        end
    endtask : t_source_select

    task automatic t_common_divider();
        int p;
        int divs[3] = '{1, 5, 63};
        foreach (divs[i]) begin
            wr(acc_pkg::ADDR_CLK_CORE_EN, {2'h2, divs[i][5:0], 8'h00});
            srcEn <= 4'h4;
            period(0, p);
            period(0, p);
            check(p[15:0], 16'(divs[i] + 1), "common period");
        end
    endtask : t_common_divider

    task automatic t_core_dividers();
        int p;
        wr(acc_pkg::ADDR_CLK_CORE_EN, 16'h018F);
        srcEn <= 4'h1;
        wr(acc_pkg::ADDR_SHARED_DIV, 16'h0002);
        for (int k = 0; k < 4; k++) wr(acc_pkg::ADDR_CORE_DIV0 + 4'(k), 16'(k));
        period(1, p);
        period(1, p);
        check(p[15:0], 16'h0006, "shared core period");
        for (int k = 0; k < 4; k++) begin
            period(2 + k, p);
            period(2 + k, p);
            check(p[15:0], 16'(2 * (k + 1)), "dedicated core period");
        end
    endtask : t_core_dividers

    // Second reset in mid-run: every field falls back to zero
    task automatic t_mid_reset();
        logic [15:0] d;
        int n;
        int p;
        @(posedge core_clk);
        resetn <= 1'b0;
        #1 check({10'h000, probe}, 16'h0000, "clocks in reset");
        check(regRdData, 16'h0000, "read data in reset");
        check({11'h000, sharedCoreEnable, dedCoreEnable}, 16'h0000, "enables in reset");
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(4'(a), d);
            check(d, 16'h0000, "register after reset");
        end
        n = 0;
        repeat (8) begin
            @(posedge core_clk);
            #1 if (probe[5:1] !== 5'h00) n++;
        end
        check(n[15:0], 16'h0000, "core clocks after reset");
        period(0, p);
        period(0, p);
        check(p[15:0], 16'h0001, "common period after reset");
    endtask : t_mid_reset

    // ******************************************************************
    // Sequence, watchdog and verdict
    // ******************************************************************
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset_and_fields();
        t_source_select();
        t_common_divider();
        t_core_dividers();
        t_mid_reset();
        tally_and_finish();
    end

    // Whole run needs well under a thousand cycles; 30000 cycles means a hang
    initial begin
        #300000;
        fails++;
        tally_and_finish();
    end
endmodule : tb_top
